// [hdl/tcd_top.sv]
/*
 Type-C downstream port attach/status controller: CC decode, switch control,
 fault, thermal shutdown, load detect and APB control/status registers.
 Assumes comparator and monitor levels are synchronous to pclk except the CC
 and enable inputs, which are resynchronised here. Open-drain pins are given
 as output enables; the pin is low while its enable is high.
*/
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcd_top
	import tcd_pkg::*;
#(
	parameter int unsigned DEB_CYC = ATTACH_DEB_CYC,
	parameter int unsigned OCG_CYC = OC_DEGLITCH_CYC
)(
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [7:0]  paddr,
	input  wire  logic [31:0] pwdata,
	input  wire  logic [3:0]  pstrb,
	output var   logic [31:0] prdata,
	output var   logic        pready,
	output var   logic        pslverr,
	input  wire  logic        enable_pin,
	input  wire  logic        charge_advert_strap,
	input  wire  logic        charge_high_strap,
	input  wire  tcd_cc_t     cc_in,
	input  wire  tcd_mon_t    mon,
	output var   logic        bus_power_on,
	output var   logic        vconn_cc1_on,
	output var   logic        vconn_cc2_on,
	output var   tcd_od_t     od_oe
);

	typedef struct packed {
		tcd_cc_t    cc_s1;
		tcd_cc_t    cc_s2;
		logic       en_s1;
		logic       en_s2;
		logic       started;
		tcd_state_t st;
		logic [31:0] deb_cnt;
		logic [31:0] oc_cnt;
		logic       oc_flt;
		logic       fault;
		logic       pwr_on;
		logic       in_ok;
		logic       vc1;
		logic       vc2;
		logic       audio;
		logic       debug;
		logic       orient;
		tcd_od_t    od;
		logic [2:0] ctrl;
		logic [31:0] rdata;
		logic       ready;
		logic       err;
	} tcd_state_all_t;

	tcd_state_all_t s_reg;
	tcd_state_all_t s_next;

	logic     en_act;
	logic     sink1;
	logic     sink2;
	logic     ld_en;
	logic     setup;
	logic     hit;

	always_comb begin
		s_next = s_reg;
		// Synchroniser second stages only read the first stages
		s_next.cc_s1 = cc_in;
		s_next.cc_s2 = s_reg.cc_s1;
		s_next.en_s1 = enable_pin;
		s_next.en_s2 = s_reg.en_s1;

		// Software can force enable off; pin high and CTRL enable both needed
		en_act = s_reg.en_s2 & s_reg.ctrl[CTRL_EN_BIT];
		sink1  = s_reg.cc_s2.cc1_rd & ~s_reg.cc_s2.cc2_rd;
		sink2  = s_reg.cc_s2.cc2_rd & ~s_reg.cc_s2.cc1_rd;

		// Input supply good with hysteresis is provided by the analog monitor
		s_next.in_ok = mon.in_good;

		// Overcurrent deglitch: must persist OCG_CYC cycles
		if (!mon.oc_raw) begin
			s_next.oc_cnt = 32'h0000_0000;
			s_next.oc_flt = 1'b0;
		end else if (s_reg.oc_cnt >= OCG_CYC - 1) begin
			s_next.oc_flt = 1'b1;
		end else begin
			s_next.oc_cnt = s_reg.oc_cnt + 32'h0000_0001;
		end

		unique case (s_reg.st)
			ST_OFF: begin
				// Startup only after aux supply good; enable is sampled then
				if (mon.aux_good && en_act) begin
					s_next.st      = ST_IDLE;
					s_next.started = 1'b1;
				end
			end
			ST_IDLE: begin
				s_next.deb_cnt = 32'h0000_0000;
				if (sink1 || sink2) begin
					s_next.st = ST_DEB;
				end
			end
			ST_DEB: begin
				if (!(sink1 || sink2)) begin
					s_next.st = ST_IDLE;
				end else if (s_reg.deb_cnt >= DEB_CYC - 1) begin
					s_next.st = ST_ATT;
				end else begin
					s_next.deb_cnt = s_reg.deb_cnt + 32'h0000_0001;
				end
			end
			ST_ATT: begin
				if (!(sink1 || sink2)) begin
					s_next.st = ST_IDLE;
				end
			end
			ST_TSD: begin
				// Restart only after the die has cooled by the hysteresis step
				if (mon.temp_cool && !mon.ot2) begin
					s_next.st = ST_OFF;
				end
			end
			default: s_next.st = ST_OFF;
		endcase

		if (mon.ot2) begin
			s_next.st = ST_TSD;
		end else if (!en_act || !mon.aux_good) begin
			// Leaving TSD is only by cooling; other states fall to OFF
			if (s_reg.st != ST_TSD) begin
				s_next.st = ST_OFF;
			end
		end

		// Switch control; first overtemp gates every switch, input supply good the bus switch
		s_next.pwr_on = (s_next.st == ST_ATT) && mon.in_good && !mon.ot1;
		s_next.vc1    = (s_next.st == ST_ATT) && sink2 && s_reg.cc_s2.cc1_ra && !mon.ot1;
		s_next.vc2    = (s_next.st == ST_ATT) && sink1 && s_reg.cc_s2.cc2_ra && !mon.ot1;

		// Fault: held while cause present, cleared once cause gone in ST_ATT or ST_IDLE
		if (s_reg.oc_flt || mon.ot1) begin
			s_next.fault = 1'b1;
		end else if (s_reg.st == ST_ATT || s_reg.st == ST_IDLE) begin
			s_next.fault = 1'b0;
		end

		// Accessory latches: set on both pins, cleared by one pin only
		if (s_reg.cc_s2.cc1_ra && s_reg.cc_s2.cc2_ra) begin
			s_next.audio = 1'b1;
		end else if (!s_reg.cc_s2.cc2_ra) begin
			s_next.audio = 1'b0;
		end
		if (s_reg.cc_s2.cc1_rd && s_reg.cc_s2.cc2_rd) begin
			s_next.debug = 1'b1;
		end else if (!s_reg.cc_s2.cc1_rd) begin
			s_next.debug = 1'b0;
		end
		s_next.orient = (s_next.st == ST_ATT) && sink2;

		ld_en = charge_advert_strap & charge_high_strap;

		// Monitoring off: outputs released, CC state forgotten
		if (s_next.st == ST_OFF || s_next.st == ST_TSD) begin
			s_next.audio = 1'b0;
			s_next.debug = 1'b0;
		end
		if (s_next.st == ST_TSD) begin
			s_next.fault = 1'b0;
		end
		// Disabled, unpowered or software-off: every open-drain pin is released
		if (s_next.st == ST_OFF) begin
			s_next.fault = 1'b0;
		end

		s_next.od.fault  = s_next.fault;
		s_next.od.sink   = (s_next.st == ST_ATT);
		s_next.od.orient = s_next.orient;
		s_next.od.audio  = s_next.audio;
		s_next.od.debug  = s_next.debug;
		s_next.od.load   = ld_en && (s_next.st == ST_ATT) && mon.load_over;

		// APB slave, zero wait states
		setup   = psel & ~penable;
		hit     = (paddr == CTRL_OFS) | (paddr == STATUS_OFS) | (paddr == ID_OFS);
		s_next.ready = setup;
		s_next.err   = setup & ~hit;
		// Write lands at the completing edge, where the access phase sees pready high
		if (psel && penable && s_reg.ready && pwrite && paddr == CTRL_OFS && pstrb[0]) begin
			s_next.ctrl = pwdata[2:0];
		end
		if (setup && !pwrite) begin
			unique case (paddr)
				CTRL_OFS:   s_next.rdata = {29'h0000_0000, s_reg.ctrl};
				STATUS_OFS: s_next.rdata = {16'h0000, 3'h0, s_reg.st, s_reg.started, s_reg.in_ok,
					s_reg.pwr_on, s_reg.fault, s_reg.audio, s_reg.debug, s_reg.orient, s_reg.od.load};
				ID_OFS:     s_next.rdata = ID_VALUE;
				default:    s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg       <= '0;
			s_reg.st    <= ST_OFF;
			s_reg.ctrl  <= CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata       = s_reg.rdata;
	assign pready       = s_reg.ready;
	assign pslverr      = s_reg.err;
	assign bus_power_on = s_reg.pwr_on;
	assign vconn_cc1_on = s_reg.vc1;
	assign vconn_cc2_on = s_reg.vc2;
	assign od_oe        = s_reg.od;

endmodule
`default_nettype wire

// [inc/tcd_pkg.sv]
/*
 Constants, register map and carrier types for the Type-C downstream port
 attach/status controller. Assumes a 40 MHz APB clock and analog comparators
 outside that deliver plain levels.
*/
package tcd_pkg;
	localparam int unsigned CLK_HZ          = 40_000_000;
	// Attach debounce in microseconds (plain default) and its cycle count
	localparam int unsigned ATTACH_DEB_US   = 150;
	localparam int unsigned ATTACH_DEB_CYC  = (ATTACH_DEB_US * (CLK_HZ / 1_000_000));
	// Overcurrent deglitch in microseconds (plain default)
	localparam int unsigned OC_DEGLITCH_US  = 8;
	localparam int unsigned OC_DEGLITCH_CYC = (OC_DEGLITCH_US * (CLK_HZ / 1_000_000));

	// APB register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ID_OFS     = 8'h08;

	// CTRL field positions
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CHG_BIT = 1;
	localparam int CTRL_CHH_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h1;

	// Identity word, value arbitrary
	localparam logic [31:0] ID_VALUE = 32'h0000_7C01;

	typedef struct packed {
		logic cc1_rd;
		logic cc1_ra;
		logic cc2_rd;
		logic cc2_ra;
	} tcd_cc_t;

	typedef struct packed {
		logic aux_good;
		logic in_good;
		logic oc_raw;
		logic ot1;
		logic ot2;
		logic temp_cool;
		logic load_over;
	} tcd_mon_t;

	typedef enum logic [4:0] {
		ST_OFF    = 5'h01,
		ST_IDLE   = 5'h02,
		ST_DEB    = 5'h04,
		ST_ATT    = 5'h08,
		ST_TSD    = 5'h10
	} tcd_state_t;

	// Open-drain status set, each a pull-low request
	typedef struct packed {
		logic fault;
		logic sink;
		logic orient;
		logic audio;
		logic debug;
		logic load;
	} tcd_od_t;
endpackage

// [bench/tcd_props.sv]
/* Port-level checker for tcd_top, bound below.
 Sees only the top's ports; DEB_CYC is handed on by the bind. */
`timescale 1ns/1ps
`default_nettype none
module tcd_props
	import tcd_pkg::*;
#(parameter int unsigned DEB_CYC = ATTACH_DEB_CYC)(
	input wire logic     pclk,
	input wire logic     presetn,
	input wire logic     enable_pin,
	input wire logic     charge_advert_strap,
	input wire logic     charge_high_strap,
	input wire tcd_cc_t  cc_in,
	input wire tcd_mon_t mon,
	input wire logic     bus_power_on,
	input wire tcd_od_t  od_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Enable passes two sync flops, hence the five-cycle window
	sequence s_en_low; !enable_pin [*5]; endsequence
	sequence s_all_off; !bus_power_on && od_oe == '0; endsequence
	property p_uv; !mon.in_good [*3] |-> !bus_power_on; endproperty
	a_uv: assert property (p_uv) else $error("switch on below supply good");
	// Overcurrent reaches the pin two cycles later, through the deglitch flag
	property p_flt; $rose(od_oe.fault) |-> $past(mon.ot1) || $past(mon.oc_raw, 2); endproperty
	a_flt: assert property (p_flt) else $error("fault without cause");
	property p_ot1; mon.ot1 [*3] |-> !bus_power_on; endproperty
	a_ot1: assert property (p_ot1) else $error("switch on when hot");
	property p_ot2; mon.ot2 |-> ##[1:4] s_all_off; endproperty
	a_ot2: assert property (p_ot2) else $error("outputs held in shutdown");
	property p_pol; od_oe.orient |-> od_oe.sink; endproperty
	a_pol: assert property (p_pol) else $error("orientation without sink");
	property p_en; s_en_low |-> s_all_off; endproperty
	a_en: assert property (p_en) else $error("active while disabled");
	property p_ld; od_oe.load |-> $past(charge_advert_strap && charge_high_strap); endproperty
	a_ld: assert property (p_ld) else $error("load flag without straps");
	property p_aux; !mon.aux_good [*3] |-> s_all_off; endproperty
	a_aux: assert property (p_aux) else $error("active before aux good");
	property p_deb; $rose(bus_power_on) |-> $past(cc_in.cc1_rd || cc_in.cc2_rd, DEB_CYC); endproperty
	a_deb: assert property (p_deb) else $error("switch on before debounce");
endmodule
bind tcd_top tcd_props #(.DEB_CYC(DEB_CYC)) u_props(.pclk, .presetn, .enable_pin, .charge_advert_strap,
	.charge_high_strap, .cc_in, .mon, .bus_power_on, .od_oe);
`default_nettype wire

// [bench/tcd_cable.sv]
/* Far-end model: cable, sink or accessory chosen by an attach code.
 Bench drives the code; the levels feed the controller's CC inputs. */
`timescale 1ns/1ps
`default_nettype none
module tcd_cable
	import tcd_pkg::*;
(
	input  wire logic [2:0] kind,
	output var  tcd_cc_t    cc
);
	// Codes 0..7: open, sink cc1, sink cc2, sink+cable, audio, Ra cc2, debug, Rd cc1
	localparam logic [31:0] TERM = 32'h8A15_9280;
	always_comb begin
		cc = TERM[kind*4 +: 4];
	end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/* Self-checking bench for tcd_top: APB reads, attach codes, monitor levels.
 Needs tcd_pkg, tcd_cable and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tcd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_power_on;
	logic        enable_pin, charge_advert_strap, charge_high_strap, vconn_cc1_on, vconn_cc2_on;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  kind;
	logic [1:0]  r;
	tcd_cc_t     cc_in;
	tcd_mon_t    mon;
	tcd_od_t     od_oe;
	int          err_total, check_count;
	logic [64:0] q[$];
	logic [64:0] nt;
	tcd_top #(.DEB_CYC(8), .OCG_CYC(4)) dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .enable_pin, .charge_advert_strap, .charge_high_strap,
		.cc_in, .mon, .bus_power_on, .vconn_cc1_on, .vconn_cc2_on, .od_oe);
	tcd_cable cable(.kind, .cc(cc_in));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic complete_run();
		if (err_total == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Monitor: each answered transfer takes the oldest note
	always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
		nt = q.pop_front();
		chk("prdata", nt[63:32], prdata & nt[31:0]);
		chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] x);
		int k;
		@(posedge pclk);
		q.push_back(x);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		{psel, penable} <= 2'b00;
		if (k >= 20) begin
			err_total++;
			complete_run();
		end
	endtask
	// Status bits 5..0: power, fault, audio, debug, orientation, load
	task automatic st(input logic [5:0] m, input logic [5:0] e);
		apb(1'b0, STATUS_OFS, 32'h0, {27'h0, e & m, 26'h0, m});
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn, kind, mon} = '0;
		{enable_pin, charge_advert_strap, charge_high_strap, err_total, check_count} = '0;
		enable_pin = 1'b1;
		void'($urandom(3017));
		wt(3);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0, {33'h1, 32'h1});
		apb(1'b0, ID_OFS, 32'h0, {1'b0, ID_VALUE, 32'hFFFF_FFFF});
		apb(1'b1, 8'h0C, 32'h1, {1'b1, 64'h0});
		kind <= 3'h1;
		wt(16);
		st(6'h3F, 6'h00);
		mon.aux_good <= 1'b1;
		wt(16);
		st(6'h20, 6'h00);
		kind <= 3'h0;
		mon.in_good <= 1'b1;
		wt(16);
		kind <= 3'h1;
		wt(3);
		st(6'h20, 6'h00);
		wt(16);
		st(6'h3F, 6'h20);
		kind <= 3'h2;
		wt(20);
		st(6'h3F, 6'h22);
		chk("od_oe", 32'h18, {26'h0, od_oe});
		kind <= 3'h3;
		wt(20);
		chk("vconn", 32'h1, {31'h0, vconn_cc2_on & ~vconn_cc1_on});
		for (int i = 4; i < 8; i++) begin
			kind <= 3'(i);
			wt(16);
			st(6'h0E, (i < 6) ? 6'h08 : 6'h04);
			chk("od_acc", {30'h0, (i < 6) ? 2'b10 : 2'b01}, {30'h0, od_oe.audio, od_oe.debug});
		end
		kind <= 3'h0;
		wt(16);
		st(6'h0C, 6'h00);
		kind <= 3'h1;
		mon.load_over <= 1'b1;
		wt(16);
		repeat (6) begin
			r = 2'($urandom);
			{charge_advert_strap, charge_high_strap} <= r;
			wt(2);
			st(6'h01, {5'h0, &r});
		end
		{charge_advert_strap, charge_high_strap, mon.load_over, mon.oc_raw} <= 4'h1;
		wt(2);
		mon.oc_raw <= 1'b0;
		wt(4);
		st(6'h10, 6'h00);
		mon.oc_raw <= 1'b1;
		wt(12);
		st(6'h10, 6'h10);
		mon.oc_raw <= 1'b0;
		wt(6);
		st(6'h10, 6'h00);
		mon.ot1 <= 1'b1;
		wt(6);
		st(6'h30, 6'h10);
		mon.ot1 <= 1'b0;
		wt(20);
		st(6'h30, 6'h20);
		mon.ot2 <= 1'b1;
		wt(6);
		chk("od_oe", 32'h0, {26'h0, od_oe});
		mon.ot2 <= 1'b0;
		wt(16);
		st(6'h20, 6'h00);
		mon.temp_cool <= 1'b1;
		wt(20);
		st(6'h20, 6'h20);
		enable_pin <= 1'b0;
		wt(8);
		chk("off", 32'h0, {25'h0, od_oe, bus_power_on});
		enable_pin <= 1'b1;
		wt(20);
		st(6'h20, 6'h20);
		apb(1'b1, CTRL_OFS, 32'h0, 65'h0);
		wt(8);
		st(6'h20, 6'h00);
		complete_run();
	end
endmodule
`default_nettype wire
